// >>> src/gdc_map.svh
// gate drive config registers: offsets, fields, reset values, timing counts
`ifndef GDC_MAP_SVH
`define GDC_MAP_SVH
// ==========================================
// register offsets (four-bit serial address)
`define GDC_ADDR_GS_FAULT 4'h4
`define GDC_ADDR_HIGH     4'h5
`define GDC_ADDR_LOW      4'h6
`define GDC_ADDR_BRIDGE   4'h7
// ==========================================
// serial word layout
`define GDC_WORD_BITS  5'h10
`define GDC_RW_BIT     15
`define GDC_ADDR_HI    14
`define GDC_ADDR_LO    11
`define GDC_DATA_HI    10
`define GDC_GS_LSB     5
// ==========================================
// reset values, writable mask, current code limit and fallback
`define GDC_DRIVE_RST  11'h344
`define GDC_BRIDGE_RST 11'h216
`define GDC_DRIVE_MASK 11'h3FF
`define GDC_CUR_MAX    4'hB
`define GDC_CUR_FALL   4'h4
// ==========================================
// timing: figures in ns, counts rounded up
`define GDC_CLK_NS     10
`define GDC_CYC(ns)    (((ns) + `GDC_CLK_NS - 1) / `GDC_CLK_NS)
`define GDC_PT0_NS     220
`define GDC_PT1_NS     440
`define GDC_PT2_NS     880
`define GDC_PT3_NS     1780
`define GDC_DT0_NS     35
`define GDC_DT1_NS     52
`define GDC_DT2_NS     88
`define GDC_DT3_NS     440
`define GDC_DT4_NS     880
`define GDC_DT5_NS     1760
`define GDC_DT6_NS     3520
`define GDC_DT7_NS     5280
`define GDC_OC1_NS     1750
`define GDC_OC2_NS     3500
`define GDC_OC3_NS     7000
`endif

// >>> src/gdc_pkg.sv
// gate drive config register types
package gdc_pkg;
  // ==========================================
  // one drive strength register, bits 9:0
  typedef struct packed {
    logic [1:0] peak_time;
    logic [3:0] sink_current;
    logic [3:0] source_current;
  } gdc_drive_t;
  // ==========================================
  // bridge control register, bits 10:0
  typedef struct packed {
    logic       pump_clock_select;
    logic       freewheel_select;
    logic [1:0] pwm_mode;
    logic [2:0] dead_time;
    logic [1:0] overcurrent_blank_time;
    logic [1:0] overcurrent_deglitch_time;
  } gdc_bridge_t;
  // ==========================================
  // decoded input scheme
  typedef enum logic [2:0] {
    GDC_PWM_SIX    = 3'h1,
    GDC_PWM_THREE  = 3'h2,
    GDC_PWM_SINGLE = 3'h4
  } gdc_pwm_t;
  // ==========================================
  // serial pins as seen at the device
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } gdc_spi_in_t;
endpackage

// >>> src/gdc_regs.sv
// gate drive config register bank with serial slave
// Functional notes
// - fault register: six gate-source flags in bits 10:5, low bits zero, reset zero
// - every config bit is writable and reads back
// - reads and fault clears never change settings
// - power-up loads default values into all config registers
// - entering sleep restores all config registers to defaults
// - high-side peak time bits 9:8, 220 to 1780 ns, default 3
// - high-side sink current bits 7:4, default 4, codes above 1011 give 60 mA
// - high-side source current bits 3:0, default 4, codes above 1011 give 50 mA
// - low-side peak time bits 9:8 at 0x6, same codes, default 3
// - low-side sink current bits 7:4, default 4, high codes give 60 mA
// - low-side source current bits 3:0, default 4, high codes give 50 mA
// - bit 10 picks charge pump clock, 0 normal, 1 reduced
// - freewheel bit 9 applies only in single input mode, default active
// - mode bits 8:7: 00/11 six inputs, 01 three, 10 one
// - 16-bit words: rw flag, four-bit address, eleven data bits; reply data
`timescale 1ns/1ps
`include "gdc_map.svh"
module gdc_regs (
  // clock, reset, enable
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  // serial pins
  input  wire gdc_pkg::gdc_spi_in_t spi_in,
  output logic                      miso_o,
  output logic                      miso_oe,
  // fault detectors and device events
  input  wire logic [5:0]           gs_fault_in,
  input  wire logic                 fault_clear_cmd,
  input  wire logic                 sleep_enter,
  // drive settings
  output gdc_pkg::gdc_drive_t       high_drive,
  output gdc_pkg::gdc_drive_t       low_drive,
  output logic [9:0]                high_peak_cycles,
  output logic [9:0]                low_peak_cycles,
  // bridge settings
  output logic                      pump_clock_select,
  output gdc_pkg::gdc_pwm_t         pwm_scheme,
  output logic                      freewheel_active,
  output logic [9:0]                dead_cycles,
  output logic [9:0]                blank_cycles,
  output logic [9:0]                deglitch_cycles
);
  // ==========================================
  // pin synchroniser
  gdc_pkg::gdc_spi_in_t pin_s1_ff;
  gdc_pkg::gdc_spi_in_t pin_s2_ff;
  logic [5:0]           gs_s1_ff;
  logic [5:0]           gs_s2_ff;
  logic                 sclk_d_ff;
  logic                 cs_n_d_ff;

  // two flops per pin; only stage two is read
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_s1_ff <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      pin_s2_ff <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      gs_s1_ff  <= 6'h00;
      gs_s2_ff  <= 6'h00;
      sclk_d_ff <= 1'b0;
      cs_n_d_ff <= 1'b1;
    end else if (clk_en) begin
      pin_s1_ff <= spi_in;
      pin_s2_ff <= pin_s1_ff;
      gs_s1_ff  <= gs_fault_in;
      gs_s2_ff  <= gs_s1_ff;
      sclk_d_ff <= pin_s2_ff.sclk;
      cs_n_d_ff <= pin_s2_ff.cs_n;
    end
  end

  // ==========================================
  // frame events
  logic sclk_fall;
  logic frame_start;
  logic frame_end;
  assign sclk_fall   = sclk_d_ff & ~pin_s2_ff.sclk & ~pin_s2_ff.cs_n;
  assign frame_start = cs_n_d_ff & ~pin_s2_ff.cs_n;
  assign frame_end   = ~cs_n_d_ff & pin_s2_ff.cs_n;

  // ==========================================
  // shifter
  logic [15:0] rx_ff;
  logic [15:0] tx_ff;
  logic [15:0] resp_ff;
  logic [4:0]  cnt_ff;
  logic        word_ok;
  logic        is_read;
  logic [3:0]  word_addr;
  logic        wr_go;

  // sample and shift out on the falling edge; host samples there too
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_ff  <= 16'h0000;
      tx_ff  <= 16'h0000;
      cnt_ff <= 5'h00;
    end else if (clk_en) begin
      if (frame_start) begin
        tx_ff  <= resp_ff;
        cnt_ff <= 5'h00;
      end else if (sclk_fall) begin
        rx_ff  <= {rx_ff[14:0], pin_s2_ff.mosi};
        tx_ff  <= {tx_ff[14:0], 1'b0};
        // saturate so an overlong frame is rejected, not wrapped
        if (cnt_ff != 5'h1F) begin
          cnt_ff <= cnt_ff + 5'h01;
        end
      end
    end
  end

  // decode of a completed word; wrong length frames are dropped
  assign word_ok   = frame_end && (cnt_ff == `GDC_WORD_BITS);
  assign is_read   = rx_ff[`GDC_RW_BIT];
  assign word_addr = rx_ff[`GDC_ADDR_HI:`GDC_ADDR_LO];
  assign wr_go     = word_ok && !is_read && !sleep_enter;

  // miso driven only inside a frame
  assign miso_o  = tx_ff[15];
  assign miso_oe = ~pin_s2_ff.cs_n;

  // ==========================================
  // configuration storage
  gdc_pkg::gdc_drive_t  high_ff;
  gdc_pkg::gdc_drive_t  low_ff;
  gdc_pkg::gdc_bridge_t bridge_ff;

  // defaults on power-up and while sleep is entered
  always_ff @(posedge core_clk) begin
    if (rst || (clk_en && sleep_enter)) begin
      high_ff   <= 10'(`GDC_DRIVE_RST);
      low_ff    <= 10'(`GDC_DRIVE_RST);
      bridge_ff <= `GDC_BRIDGE_RST;
    end else if (clk_en && wr_go) begin
      // bit 10 of the drive words is reserved: dropped
      case (word_addr)
        `GDC_ADDR_HIGH: begin
          high_ff <= rx_ff[9:0];
        end
        `GDC_ADDR_LOW: begin
          low_ff <= rx_ff[9:0];
        end
        `GDC_ADDR_BRIDGE: begin
          bridge_ff <= rx_ff[`GDC_DATA_HI:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================
  // gate-source fault flags
  logic [5:0] gs_ff;

  // sticky; a new fault beats a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gs_ff <= 6'h00;
    end else if (clk_en) begin
      gs_ff <= (fault_clear_cmd ? 6'h00 : gs_ff) | gs_s2_ff;
    end
  end

  // ==========================================
  // read mux, unmapped and reserved bits zero
  logic [10:0] rd_data;
  always_comb begin
    rd_data = 11'h000;
    case (word_addr)
      `GDC_ADDR_GS_FAULT: rd_data = {gs_ff, 5'h00};
      `GDC_ADDR_HIGH:     rd_data = {1'b0, high_ff};
      `GDC_ADDR_LOW:      rd_data = {1'b0, low_ff};
      `GDC_ADDR_BRIDGE:   rd_data = bridge_ff;
      default:            rd_data = 11'h000;
    endcase
  end

  // reply takes contents before this frame's own write; shifted out next frame
  always_ff @(posedge core_clk) begin
    if (rst) begin
      resp_ff <= 16'h0000;
    end else if (clk_en && word_ok) begin
      resp_ff <= {5'h00, rd_data};
    end
  end

  // ==========================================
  // setting decode
  function automatic logic [3:0] cur_eff(input logic [3:0] code);
    // upper codes fall back to the code 4 current
    cur_eff = (code > `GDC_CUR_MAX) ? `GDC_CUR_FALL : code;
  endfunction

  function automatic logic [9:0] peak_cyc(input logic [1:0] code);
    case (code)
      2'h0:    peak_cyc = 10'(`GDC_CYC(`GDC_PT0_NS));
      2'h1:    peak_cyc = 10'(`GDC_CYC(`GDC_PT1_NS));
      2'h2:    peak_cyc = 10'(`GDC_CYC(`GDC_PT2_NS));
      default: peak_cyc = 10'(`GDC_CYC(`GDC_PT3_NS));
    endcase
  endfunction

  // code 0 means no filtering, so zero cycles here
  function automatic logic [9:0] oc_cyc(input logic [1:0] code);
    case (code)
      2'h0:    oc_cyc = 10'h000;
      2'h1:    oc_cyc = 10'(`GDC_CYC(`GDC_OC1_NS));
      2'h2:    oc_cyc = 10'(`GDC_CYC(`GDC_OC2_NS));
      default: oc_cyc = 10'(`GDC_CYC(`GDC_OC3_NS));
    endcase
  endfunction

  // drive outputs with the fallback applied
  always_comb begin
    high_drive                = high_ff;
    high_drive.sink_current   = cur_eff(high_ff.sink_current);
    high_drive.source_current = cur_eff(high_ff.source_current);
    low_drive                 = low_ff;
    low_drive.sink_current    = cur_eff(low_ff.sink_current);
    low_drive.source_current  = cur_eff(low_ff.source_current);
  end

  assign high_peak_cycles  = peak_cyc(high_ff.peak_time);
  assign low_peak_cycles   = peak_cyc(low_ff.peak_time);
  assign pump_clock_select = bridge_ff.pump_clock_select;
  assign blank_cycles      = oc_cyc(bridge_ff.overcurrent_blank_time);
  assign deglitch_cycles   = oc_cyc(bridge_ff.overcurrent_deglitch_time);

  // input scheme; 11 aliases the six input mode
  always_comb begin
    case (bridge_ff.pwm_mode)
      2'h1:    pwm_scheme = gdc_pkg::GDC_PWM_THREE;
      2'h2:    pwm_scheme = gdc_pkg::GDC_PWM_SINGLE;
      default: pwm_scheme = gdc_pkg::GDC_PWM_SIX;
    endcase
  end

  // ignored outside single input mode
  assign freewheel_active = bridge_ff.freewheel_select && (pwm_scheme == gdc_pkg::GDC_PWM_SINGLE);

  // dead time lookup
  always_comb begin
    case (bridge_ff.dead_time)
      3'h0:    dead_cycles = 10'(`GDC_CYC(`GDC_DT0_NS));
      3'h1:    dead_cycles = 10'(`GDC_CYC(`GDC_DT1_NS));
      3'h2:    dead_cycles = 10'(`GDC_CYC(`GDC_DT2_NS));
      3'h3:    dead_cycles = 10'(`GDC_CYC(`GDC_DT3_NS));
      3'h4:    dead_cycles = 10'(`GDC_CYC(`GDC_DT4_NS));
      3'h5:    dead_cycles = 10'(`GDC_CYC(`GDC_DT5_NS));
      3'h6:    dead_cycles = 10'(`GDC_CYC(`GDC_DT6_NS));
      default: dead_cycles = 10'(`GDC_CYC(`GDC_DT7_NS));
    endcase
  end

  // ==========================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_power_default: assert property (disable iff (1'b0) rst |=>
    high_ff == 10'(`GDC_DRIVE_RST) && bridge_ff == `GDC_BRIDGE_RST)
    else $error("defaults not loaded after reset");
  chk_sleep_default: assert property (clk_en && sleep_enter |=>
    low_ff == 10'(`GDC_DRIVE_RST) && bridge_ff == `GDC_BRIDGE_RST)
    else $error("sleep did not restore defaults");
  chk_write_high: assert property (clk_en && wr_go && word_addr == `GDC_ADDR_HIGH
    |=> high_ff == $past(rx_ff[9:0]))
    else $error("high drive write lost");
  chk_cfg_hold: assert property (!(clk_en && (wr_go || sleep_enter))
    |=> $stable({high_ff, low_ff, bridge_ff}))
    else $error("setting changed without write");
  chk_status_zero: assert property (word_addr == `GDC_ADDR_GS_FAULT
    |-> rd_data[4:0] == 5'h00 && rd_data[10:5] == gs_ff)
    else $error("fault register layout wrong");
  chk_fault_sticky: assert property (clk_en && gs_ff[0] && !fault_clear_cmd |=> gs_ff[0])
    else $error("fault flag dropped");
  chk_fault_set: assert property (clk_en && fault_clear_cmd && gs_s2_ff[5] |=> gs_ff[5])
    else $error("clear beat a new fault");
  chk_sink_fall: assert property (high_ff.sink_current > 4'hB |-> high_drive.sink_current == 4'h4)
    else $error("sink fallback wrong");
  chk_src_fall: assert property (low_ff.source_current > 4'hB |-> low_drive.source_current == 4'h4)
    else $error("source fallback wrong");
  chk_freewheel_mode: assert property (freewheel_active |-> bridge_ff.pwm_mode == 2'h2)
    else $error("freewheel outside single mode");
  chk_mode_alias: assert property (bridge_ff.pwm_mode == 2'h3 |-> pwm_scheme == gdc_pkg::GDC_PWM_SIX)
    else $error("mode 11 not six inputs");
  chk_reply_upper: assert property (clk_en && word_ok |=> resp_ff[15:11] == 5'h00
    && resp_ff[10:0] == $past(rd_data))
    else $error("reply word wrong");

  cov_write_frame: cover property (clk_en && wr_go);
  cov_read_frame: cover property (clk_en && word_ok && is_read);
  cov_sleep: cover property (clk_en && sleep_enter);
  cov_single_mode: cover property (freewheel_active);
endmodule

// >>> verif/gdc_host.sv
// host model: serial master driving the config register port
`timescale 1ns/1ps
module gdc_host (
  // clock
  input  wire logic            core_clk,
  // serial pins
  output gdc_pkg::gdc_spi_in_t spi_in,
  input  wire logic            miso_o,
  input  wire logic            miso_oe
);
  // ==========================================
  // idle pins: deselected, clock low
  initial begin
    spi_in = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
  end
  // wait n edges, then step off the edge
  task automatic pause(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // ==========================================
  // one frame, msb first; phases of 4 cycles clear the two-flop sync
  task automatic xfer(input logic [15:0] word, output logic [15:0] reply);
    pause(1);
    spi_in.cs_n = 1'b0;
    pause(4);
    for (int i = 15; i >= 0; i--) begin
      spi_in.mosi = word[i];
      pause(4);
      spi_in.sclk = 1'b1;
      pause(4);
      reply[i] = miso_oe ? miso_o : 1'bx;
      spi_in.sclk = 1'b0;
      pause(4);
    end
    spi_in.cs_n = 1'b1;
    // deselected line must not look like a held bit
    spi_in.mosi = ~spi_in.mosi;
    pause(6);
  endtask
endmodule

// >>> verif/gdc_regs_bench.sv
// self-checking bench for the gate drive config register bank
`timescale 1ns/1ps
`include "gdc_map.svh"
module gdc_regs_bench;
  // ==========================================
  // stimulus and observed signals
  logic                 core_clk;
  logic                 rst;
  logic                 clk_en;
  logic                 fault_clear_cmd;
  logic                 sleep_enter;
  logic [5:0]           gs_fault_in;
  gdc_pkg::gdc_spi_in_t spi_in;
  logic                 miso_o;
  logic                 miso_oe;
  gdc_pkg::gdc_drive_t  high_drive;
  gdc_pkg::gdc_drive_t  low_drive;
  logic [9:0]           high_peak_cycles;
  logic [9:0]           low_peak_cycles;
  logic                 pump_clock_select;
  gdc_pkg::gdc_pwm_t    pwm_scheme;
  logic                 freewheel_active;
  logic [9:0]           dead_cycles;
  logic [9:0]           blank_cycles;
  logic [9:0]           deglitch_cycles;
  logic [10:0]          bw;
  int                   err_total;
  int                   checked;
  int                   cycles;
  // expected counts per code at 10 ns per cycle
  logic [9:0]           dead_tab [8] = '{10'h004, 10'h006, 10'h009, 10'h02C, 10'h058, 10'h0B0, 10'h160, 10'h210};
  logic [9:0]           oc_tab [4]   = '{10'h000, 10'h0AF, 10'h15E, 10'h2BC};
  logic [2:0]           pwm_tab [4]  = '{3'h1, 3'h2, 3'h4, 3'h1};

  // ==========================================
  // design and host
  gdc_regs gdc_regs_inst (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .spi_in(spi_in), .miso_o(miso_o),
    .miso_oe(miso_oe), .gs_fault_in(gs_fault_in), .fault_clear_cmd(fault_clear_cmd),
    .sleep_enter(sleep_enter), .high_drive(high_drive), .low_drive(low_drive),
    .high_peak_cycles(high_peak_cycles), .low_peak_cycles(low_peak_cycles),
    .pump_clock_select(pump_clock_select), .pwm_scheme(pwm_scheme),
    .freewheel_active(freewheel_active), .dead_cycles(dead_cycles),
    .blank_cycles(blank_cycles), .deglitch_cycles(deglitch_cycles)
  );
  gdc_host gdc_host_inst (
    .core_clk(core_clk), .spi_in(spi_in), .miso_o(miso_o), .miso_oe(miso_oe)
  );

  // ==========================================
  // compare, verdict and register access
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] addr, input logic [10:0] data);
    logic [15:0] rsp;
    gdc_host_inst.xfer({1'b0, addr, data}, rsp);
  endtask
  // reply trails by one frame, so the second frame carries the answer
  task automatic rd(input logic [3:0] addr, input logic [10:0] exp);
    logic [15:0] rsp;
    gdc_host_inst.xfer({1'b1, addr, 11'h000}, rsp);
    gdc_host_inst.xfer({1'b1, addr, 11'h000}, rsp);
    cmp(rsp, {5'h00, exp});
  endtask

  // ==========================================
  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      finish_test();
    end
  end

  // ==========================================
  // main sequence
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    fault_clear_cmd = 1'b0;
    sleep_enter = 1'b0;
    gs_fault_in = 6'h00;
    repeat (4) @(posedge core_clk);
    #1;
    rst = 1'b0;
    // defaults straight out of reset
    rd(`GDC_ADDR_HIGH, 11'h344);
    rd(`GDC_ADDR_LOW, 11'h344);
    rd(`GDC_ADDR_BRIDGE, 11'h216);
    rd(`GDC_ADDR_GS_FAULT, 11'h000);
    cmp({6'h00, high_peak_cycles}, 16'h00B2);
    // reserved bit dropped, fallback current codes on outputs
    wr(`GDC_ADDR_HIGH, 11'h7FF);
    rd(`GDC_ADDR_HIGH, 11'h3FF);
    cmp({6'h00, high_drive}, 16'h0344);
    wr(`GDC_ADDR_LOW, 11'h2BA);
    rd(`GDC_ADDR_LOW, 11'h2BA);
    cmp({6'h00, low_drive}, 16'h02BA);
    cmp({6'h00, low_peak_cycles}, 16'h0058);
    // every bridge code, freewheel set so single mode shows it
    for (int i = 0; i < 8; i++) begin
      bw = {i[0], 1'b1, i[1:0], i[2:0], i[1:0], ~i[1:0]};
      wr(`GDC_ADDR_BRIDGE, bw);
      rd(`GDC_ADDR_BRIDGE, bw);
      cmp({15'h0000, pump_clock_select}, {15'h0000, bw[10]});
      cmp({13'h0000, pwm_scheme}, {13'h0000, pwm_tab[i[1:0]]});
      cmp({15'h0000, freewheel_active}, {15'h0000, i[1:0] == 2'h2});
      cmp({6'h00, dead_cycles}, {6'h00, dead_tab[i]});
      cmp({6'h00, blank_cycles}, {6'h00, oc_tab[i[1:0]]});
      cmp({6'h00, deglitch_cycles}, {6'h00, oc_tab[~i[1:0]]});
    end
    wr(`GDC_ADDR_BRIDGE, 11'h100);
    cmp({15'h0000, freewheel_active}, 16'h0000);
    // status write ignored, flags sticky until cleared
    gs_fault_in = 6'h2D;
    wr(`GDC_ADDR_GS_FAULT, 11'h7FF);
    gs_fault_in = 6'h00;
    rd(`GDC_ADDR_GS_FAULT, 11'h5A0);
    // a fault arriving during a clear must survive it
    fault_clear_cmd = 1'b1;
    gs_fault_in = 6'h20;
    repeat (3) @(posedge core_clk);
    #1;
    fault_clear_cmd = 1'b0;
    gs_fault_in = 6'h00;
    rd(`GDC_ADDR_GS_FAULT, 11'h400);
    fault_clear_cmd = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    fault_clear_cmd = 1'b0;
    rd(`GDC_ADDR_GS_FAULT, 11'h000);
    rd(`GDC_ADDR_LOW, 11'h2BA);
    rd(`GDC_ADDR_BRIDGE, 11'h100);
    // frozen core must not act on a sleep request
    clk_en = 1'b0;
    sleep_enter = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    sleep_enter = 1'b0;
    clk_en = 1'b1;
    cmp({6'h00, low_drive}, 16'h02BA);
    cmp({13'h0000, pwm_scheme}, 16'h0004);
    // sleep restores defaults and blocks writes
    sleep_enter = 1'b1;
    wr(`GDC_ADDR_HIGH, 11'h0AA);
    sleep_enter = 1'b0;
    rd(`GDC_ADDR_HIGH, 11'h344);
    rd(`GDC_ADDR_LOW, 11'h344);
    rd(`GDC_ADDR_BRIDGE, 11'h216);
    rd(4'h9, 11'h000);
    finish_test();
  end
endmodule
